// ==== pspmc_top.v ====
`timescale 1ns/1ps
module pspmc_top #(
   parameter NPIN = 8
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire supply_stable,
   input wire internal_reset,
   input wire external_reset_n_pin,
   input wire osc_stop,
   input wire [NPIN-1:0] core_oe,
   input wire [NPIN-1:0] core_out,
   input wire [NPIN-1:0] pad_in,
   output wire [NPIN-1:0] pad_oe_n,
   output wire [NPIN-1:0] pad_out,
   output wire [NPIN-1:0] core_in,
   output wire [NPIN-1:0] pad_pull_up,
   output wire [NPIN-1:0] pad_ana_en,
   output wire [NPIN-1:0] wakeup_input
);
`include "pspmc_map.vh"
   reg standby_pin_level_bit_r;
   reg [2:0] mode_r;
   reg [4*NPIN-1:0] fsel_r;
   reg [NPIN-1:0] pfb_r;
   reg [4*NPIN-1:0] fsel_eff_r;
   reg [NPIN-1:0] hold_oe_r;
   reg [NPIN-1:0] hold_out_r;
   reg [2:0] sync_a_r;
   reg [2:0] sync_b_r;
   reg [5:0] st;
   wire [NPIN-1:0] oe_n_w;
   wire [NPIN-1:0] out_w;
   wire [NPIN-1:0] in_w;
   wire [NPIN-1:0] pu_w;
   wire [NPIN-1:0] ana_w;
   wire [NPIN-1:0] wk_w;
   wire wr_en;
   wire rst_pin_low;
   wire sup_ok;
   wire irst;
   wire mapped;
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite & clk_en;
   assign mapped = (paddr == `PSPMC_OFF_STBY) | (paddr == `PSPMC_OFF_MODE) | (paddr == `PSPMC_OFF_FSEL) |
      (paddr == `PSPMC_OFF_PFB) | (paddr == `PSPMC_OFF_STAT);
   assign pslverr = psel & penable & ~mapped;
   // Two-stage synchronisers for the reset pin, supply flag and internal reset.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a_r <= 3'h0;
         sync_b_r <= 3'h0;
      end else if (clk_en) begin
         sync_a_r <= {internal_reset, supply_stable, ~external_reset_n_pin};
         sync_b_r <= sync_a_r;
      end
   end
   assign rst_pin_low = sync_b_r[0];
   assign sup_ok = sync_b_r[1];
   assign irst = sync_b_r[2];
   // One-hot power state; the reset pin low has priority over internal reset.
   always @* begin
      st = 6'h00;
      if (!sup_ok) begin
         st[0] = 1'b1;
      end else if (rst_pin_low) begin
         st[1] = 1'b1;
      end else if (irst) begin
         st[2] = 1'b1;
      end else if (mode_r == `PSPMC_MD_LOWPWR) begin
         st[4] = 1'b1;
      end else if (mode_r == `PSPMC_MD_DEEP) begin
         st[5] = 1'b1;
      end else begin
         st[3] = 1'b1;
      end
   end
   // Register writes; software settings reach the pads in reset states as well.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_pin_level_bit_r <= 1'b0;
         mode_r <= `PSPMC_MODE_RST;
         fsel_r <= {4*NPIN{1'b0}};
         pfb_r <= {NPIN{1'b0}};
      end else if (wr_en) begin
         case (paddr)
            `PSPMC_OFF_STBY: begin
               standby_pin_level_bit_r <= pwdata[`PSPMC_SPL_BIT];
            end
            `PSPMC_OFF_MODE: begin
               mode_r <= pwdata[2:0];
            end
            `PSPMC_OFF_FSEL: begin
               fsel_r <= pwdata[4*NPIN-1:0];
            end
            `PSPMC_OFF_PFB: begin
               pfb_r <= pwdata[NPIN-1:0];
            end
            default: begin
            end
         endcase
      end
   end
   // Effective selection follows software in run and reset states; standby states hold it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_eff_r <= {4*NPIN{1'b0}};
      end else if (clk_en) begin
         if (st[1] | st[2] | st[0]) begin
            fsel_eff_r <= fsel_r;
         end else if (st[3]) begin
            fsel_eff_r <= fsel_r;
         end
      end
   end
   // Capture pad drive while running so standby states can hold it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_oe_r <= {NPIN{1'b0}};
         hold_out_r <= {NPIN{1'b0}};
      end else if (clk_en && st[3]) begin
         hold_oe_r <= ~oe_n_w;
         hold_out_r <= out_w;
      end
   end
   // Read mux; status shows the six-bit one-hot state only.
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `PSPMC_OFF_STBY: prdata[`PSPMC_SPL_BIT] = standby_pin_level_bit_r;
         `PSPMC_OFF_MODE: prdata[2:0] = mode_r;
         `PSPMC_OFF_FSEL: prdata[4*NPIN-1:0] = fsel_r;
         `PSPMC_OFF_PFB: prdata[NPIN-1:0] = pfb_r;
         `PSPMC_OFF_STAT: prdata[5:0] = st;
         default: prdata = 32'h0000_0000;
      endcase
   end
   // One pad decoder per pin.
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_pad
         pspmc_pad u_pad (
            .fn(fsel_eff_r[4*g+3:4*g]),
            .st(st),
            .standby_pin_level_bit(standby_pin_level_bit_r),
            .pfb(pfb_r[g]),
            .osc_stop(osc_stop),
            .hold_oe(hold_oe_r[g]),
            .hold_out(hold_out_r[g]),
            .core_oe(core_oe[g]),
            .core_out(core_out[g]),
            .pad_in(pad_in[g]),
            .drv_oe_n(oe_n_w[g]),
            .drv_out(out_w[g]),
            .in_core(in_w[g]),
            .pull_up(pu_w[g]),
            .ana_en(ana_w[g]),
            .wake_in(wk_w[g])
         );
      end
   endgenerate
   assign pad_oe_n = oe_n_w;
   assign pad_out = out_w;
   assign core_in = in_w;
   assign pad_pull_up = pu_w;
   assign pad_ana_en = ana_w;
   assign wakeup_input = wk_w;
endmodule // pspmc_top

// ==== pspmc_map.vh ====
`ifndef PSPMC_MAP_VH
`define PSPMC_MAP_VH
// Register byte offsets.
`define PSPMC_OFF_STBY 12'h000
`define PSPMC_OFF_MODE 12'h004
`define PSPMC_OFF_FSEL 12'h008
`define PSPMC_OFF_PFB 12'h00C
`define PSPMC_OFF_STAT 12'h010
// Field positions of the standby control register.
`define PSPMC_SPL_BIT 0
// Reset values.
`define PSPMC_STBY_RST 32'h0000_0000
`define PSPMC_MODE_RST 3'h0
// Power modes written by software.
`define PSPMC_MD_RUN 3'h0
`define PSPMC_MD_LOWPWR 3'h1
`define PSPMC_MD_DEEP 3'h2
`define PSPMC_MD_RETURN 3'h3
// Pin function codes, four bits per pin.
`define PSPMC_FN_PORT 4'h0
`define PSPMC_FN_PERIPH 4'h1
`define PSPMC_FN_ANALOG 4'h2
`define PSPMC_FN_WAKEUP 4'h3
`define PSPMC_FN_EXTINT 4'h4
`define PSPMC_FN_EXTCLK 4'h5
`define PSPMC_FN_XIN 4'h6
`define PSPMC_FN_XOUT 4'h7
`define PSPMC_FN_RESET 4'h8
`define PSPMC_FN_MODE 4'h9
`define PSPMC_FN_DEBUG 4'hA
`endif

// ==== pspmc_pad.v ====
`timescale 1ns/1ps
// Per-pin pad decode of function, power state and standby level.
module pspmc_pad (
   input wire [3:0] fn,
   input wire [5:0] st,
   input wire standby_pin_level_bit,
   input wire pfb,
   input wire osc_stop,
   input wire hold_oe,
   input wire hold_out,
   input wire core_oe,
   input wire core_out,
   input wire pad_in,
   output reg drv_oe_n,
   output reg drv_out,
   output reg in_core,
   output reg pull_up,
   output reg ana_en,
   output reg wake_in
);
`include "pspmc_map.vh"
   // State one-hot bits: unstable, pin low, internal reset, run, low power, deep standby.
   localparam ST_UNST = 0;
   localparam ST_RPIN = 1;
   localparam ST_IRST = 2;
   localparam ST_RUN = 3;
   localparam ST_LOW = 4;
   localparam ST_DEEP = 5;
   reg oe;
   reg ien;
   reg held;
   reg rst_any;
   // Decode the pad state combinationally from its inputs.
   always @* begin
      oe = 1'b0;
      ien = 1'b0;
      held = 1'b0;
      pull_up = 1'b0;
      ana_en = 1'b0;
      wake_in = 1'b0;
      rst_any = st[ST_UNST] | st[ST_RPIN] | st[ST_IRST];
      case (fn)
         `PSPMC_FN_RESET: begin
            pull_up = 1'b1;
            ien = 1'b1;
         end
         `PSPMC_FN_MODE, `PSPMC_FN_XIN: begin
            ien = 1'b1;
         end
         `PSPMC_FN_ANALOG: begin
            ana_en = ~st[ST_UNST];
         end
         `PSPMC_FN_XOUT: begin
            if (!rst_any && !osc_stop) begin
               oe = core_oe;
            end
         end
         `PSPMC_FN_DEBUG: begin
            if (st[ST_RPIN] | st[ST_IRST]) begin
               pull_up = 1'b1;
               ien = 1'b1;
            end else if (!st[ST_UNST]) begin
               held = st[ST_LOW] | st[ST_DEEP];
               oe = held ? hold_oe : core_oe;
               ien = 1'b1;
            end
         end
         default: begin
            if (st[ST_RPIN] | st[ST_IRST]) begin
               ien = 1'b1;
            end else if (st[ST_RUN]) begin
               oe = core_oe;
               ien = 1'b1;
            end else if (st[ST_LOW]) begin
               if (fn == `PSPMC_FN_EXTINT) begin
                  oe = core_oe;
                  ien = 1'b1;
               end else if (fn == `PSPMC_FN_EXTCLK) begin
                  oe = standby_pin_level_bit ? 1'b0 : hold_oe;
                  held = ~standby_pin_level_bit;
                  ien = standby_pin_level_bit & ~osc_stop;
               end else if (fn == `PSPMC_FN_PERIPH && !standby_pin_level_bit) begin
                  oe = core_oe;
                  ien = 1'b1;
               end else begin
                  held = ~standby_pin_level_bit;
                  oe = standby_pin_level_bit ? 1'b0 : hold_oe;
               end
            end else if (st[ST_DEEP]) begin
               held = ~standby_pin_level_bit;
               oe = standby_pin_level_bit ? 1'b0 : hold_oe;
               wake_in = (fn == `PSPMC_FN_WAKEUP);
               if (fn == `PSPMC_FN_PERIPH && !pfb) begin
                  held = 1'b0;
                  oe = core_oe;
                  ien = 1'b1;
               end
            end
         end
      endcase
      drv_oe_n = ~oe;
      drv_out = held ? hold_out : core_out;
      in_core = ien & pad_in;
   end
endmodule // pspmc_pad

// ==== pspmc_board.sv ====
`timescale 1ns/1ps
// Board side of the pads: resolves each pin wire from every party that can drive it.
module pspmc_board (
   input wire pclk,
   input wire [7:0] pad_oe_n,
   input wire [7:0] pad_out,
   input wire [7:0] pad_pull_up,
   input wire ext_drv,
   input wire [7:0] ext_val,
   output logic [7:0] pad_in
);
   logic [7:0] noise_r = 8'h5a;
   // An undriven wire wanders so that a stale level never passes for a drive.
   always @(posedge pclk) noise_r <= ~noise_r;
   // Device driver wins, then the board, then the pull-up, else noise.
   always_comb for (int k = 0; k < 8; k++) pad_in[k] = !pad_oe_n[k] ? pad_out[k] :
      ext_drv ? ext_val[k] : (pad_pull_up[k] | noise_r[k]);
endmodule // pspmc_board

// ==== pspmc_monitor.sv ====
`timescale 1ns/1ps
// Watches the pad outputs against power, reset and bus inputs.
module pspmc_monitor #(parameter NPIN = 8) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire supply_stable,
   input wire internal_reset,
   input wire external_reset_n_pin,
   input wire [NPIN-1:0] pad_in,
   input wire [NPIN-1:0] pad_oe_n,
   input wire [NPIN-1:0] core_in,
   input wire [NPIN-1:0] pad_pull_up,
   input wire [NPIN-1:0] pad_ana_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   unstable_float_a: assert property ((!supply_stable && clk_en) [*3] |-> &pad_oe_n && !(|pad_ana_en))
      else $error("pins not floating with supply unstable");
   rstpin_float_a: assert property ((!external_reset_n_pin && clk_en) [*3] |-> &pad_oe_n)
      else $error("driver on while reset pin low");
   intrst_float_a: assert property ((internal_reset && clk_en) [*3] |-> &pad_oe_n)
      else $error("driver on during internal reset");
   analog_drv_a: assert property (!(|(pad_ana_en & ~pad_oe_n)))
      else $error("analog pin has driver on");
   analog_gate_a: assert property (!(|(pad_ana_en & core_in)))
      else $error("analog pin input not gated");
   pullup_input_a: assert property ((pad_pull_up & (core_in ^ pad_in)) == '0)
      else $error("pulled-up pin input not passed");
   unmapped_read_a: assert property (psel && penable && !pwrite && paddr > 12'h010 |-> pslverr && prdata == '0)
      else $error("unmapped read not refused");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   cover property (&pad_oe_n && supply_stable);
   cover property (|pad_ana_en);
   cover property (pslverr);
endmodule // pspmc_monitor
bind pspmc_top pspmc_monitor #(.NPIN(NPIN)) i_pspmc_monitor (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pslverr(pslverr), .supply_stable(supply_stable), .internal_reset(internal_reset),
   .external_reset_n_pin(external_reset_n_pin), .pad_in(pad_in), .pad_oe_n(pad_oe_n), .core_in(core_in),
   .pad_pull_up(pad_pull_up), .pad_ana_en(pad_ana_en));

// ==== pspmc_top_bench.sv ====
`timescale 1ns/1ps
`include "pspmc_map.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pspmc_top_bench;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, sup = 0, irst = 0;
   logic rpin = 1, osc = 0, drv = 1, er, s;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [7:0] oe = 0, co = 0, ev = 0, h, pe;
   logic [2:0] m;
   wire pready, pslverr;
   wire [31:0] prdata;
   wire [7:0] pin, poe_n, pout, cin, pu, ana, wk;
   integer err_count = 0, tests_run = 0, seed = 32'hee8b, i;
   // Free-running bus clock.
   always #4 pclk = ~pclk;
   pspmc_top #(.NPIN(8)) i_pspmc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .supply_stable(sup), .internal_reset(irst), .external_reset_n_pin(rpin),
      .osc_stop(osc), .core_oe(oe), .core_out(co), .pad_in(pin), .pad_oe_n(poe_n), .pad_out(pout),
      .core_in(cin), .pad_pull_up(pu), .pad_ana_en(ana), .wakeup_input(wk));
   pspmc_board i_pspmc_board (.pclk(pclk), .pad_oe_n(poe_n), .pad_out(pout), .pad_pull_up(pu),
      .ext_drv(drv), .ext_val(ev), .pad_in(pin));
   // One bus transfer, held until pready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'h1 && n++ < 20);
      if (pready !== 1'h1) err_count++;
      rd = prdata; er = pslverr; psel <= 0; penable <= 0;
   endtask
   // Standby level first, then the power mode, then let the pads settle.
   task st(input logic [2:0] md, input logic sp);
      apb(1, `PSPMC_OFF_STBY, {31'h0, sp}); apb(1, `PSPMC_OFF_MODE, {29'h0, md}); repeat (3) @(posedge pclk);
   endtask
   // A port pin floats only in a standby mode with the level bit set.
   function logic flt(input logic [2:0] md, input logic sp);
      return (md == `PSPMC_MD_LOWPWR || md == `PSPMC_MD_DEEP) ? sp : 1'h0;
   endfunction
   task results;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin #100000; err_count++; results(); end
   // Main sequence.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1; sup <= 1;
      apb(0, `PSPMC_OFF_STBY, 0); `CHK(rd, 32'h0000_0000)
      apb(0, 12'h014, 0); `CHK({er, rd}, 33'h1_0000_0000)
      apb(1, `PSPMC_OFF_FSEL, 32'h8654_3210); apb(1, `PSPMC_OFF_PFB, 32'h0000_0002);
      for (i = 0; i < 4; i++) begin
         m = (i < 2) ? `PSPMC_MD_LOWPWR : `PSPMC_MD_DEEP; s = i[0];
         oe <= 8'hff; co <= $random(seed); ev <= $random(seed); st(`PSPMC_MD_RUN, 0);
         h = co; pe = poe_n;
         `CHK(pout[1:0], h[1:0])
         `CHK({pu[7], cin[7], cin[6]}, {1'h1, pin[7], pin[6]})
         st(m, s); co <= $random(seed); oe <= $random(seed); repeat (2) @(posedge pclk);
         `CHK({poe_n[0], cin[0]}, {flt(m, s), 1'h0})
         if (!s) `CHK(pout[0], h[0])
         `CHK({poe_n[2], cin[2], ana[2]}, 3'h5)
         if (m == `PSPMC_MD_DEEP && !s) `CHK({poe_n[1], pout[1]}, {1'h0, h[1]})
         if (m == `PSPMC_MD_DEEP && s) `CHK({poe_n[3], wk[3]}, 2'h3)
         if (m == `PSPMC_MD_LOWPWR && s) `CHK(poe_n[4], ~oe[4])
      end
      st(`PSPMC_MD_RUN, 0); rpin <= 0; repeat (4) @(posedge pclk);
      `CHK(poe_n, 8'hff)
      `CHK({pu[7], cin[7], cin[0]}, {1'h1, pin[7], pin[0]})
      rpin <= 1; irst <= 1; repeat (4) @(posedge pclk);
      `CHK(poe_n, 8'hff)
      irst <= 0; sup <= 0; repeat (4) @(posedge pclk);
      `CHK({poe_n, ana}, 16'hff00)
      sup <= 1; apb(1, `PSPMC_OFF_FSEL, 32'h8674_3210); osc <= 1; repeat (4) @(posedge pclk);
      `CHK({poe_n[5], cin[5]}, 2'h2)
      clk_en <= 0; apb(1, `PSPMC_OFF_STBY, 1); clk_en <= 1; apb(0, `PSPMC_OFF_STBY, 0);
      `CHK(rd[0], 1'h0)
      results();
   end
endmodule // pspmc_top_bench
